// [verilog/qfstc_top.sv]
// Purpose: host register slice for rx frame status and tx queue commands
// Assumes: host bus sampled synchronously; 16-bit words, 8-bit lane select
// Notes:   rx status held for four queued frames in a small array
//
// Behaviour
// - valid bit reads 1 only for a complete queued frame at the head
// - bit 13 flags ICMP checksum failure
// - bit 12 flags IPv4 header checksum failure
// - bit 11 flags TCP checksum failure
// - bit 10 flags UDP checksum failure
// - bit 7 flags broadcast destination
// - bit 6 flags multicast destination, broadcast included
// - bit 5 flags unicast destination
// - bit 3 set for length/type above 1500, else 802.3 frame
// - bit 1 flags runt frames, passed only with pass-bad-frame
// - bit 0 flags CRC error, passed only with pass-bad-frame
// - one status word per frame, counted by the rx frame count
// - byte count in bits 11..0, upper four bits read zero
// - monitor command raises interrupt bit 6 when free space suffices
// - monitor bit self-clears after frame transmits, or once fired with no frame in flight; host waits
// - enqueue command queues the current tx frame, one per command
// - enqueue bit self-clears when transmission completes
// - free tx memory in bytes, 13 bits, resets to 0x1800
`timescale 1ns/1ps
module qfstc_top
  import qfstc_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        rstn_i,
  // host register port
  input  wire logic        reg_sel_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic [10:0] reg_addr_i,
  input  wire logic [1:0]  reg_be_i,
  input  wire logic [15:0] reg_wdata_i,
  output logic      [15:0] reg_rdata_o,
  // pass-bad-frame setting from rx control
  input  wire logic        pass_bad_frame_i,
  // receive side frame report
  input  wire logic        rx_frame_done_i,
  input  wire logic [11:0] rx_frame_bytes_i,
  input  wire logic [47:0] rx_dest_addr_i,
  input  wire logic [15:0] rx_len_type_i,
  input  wire logic        rx_icmp_err_i,
  input  wire logic        rx_iphdr_err_i,
  input  wire logic        rx_tcp_err_i,
  input  wire logic        rx_udp_err_i,
  input  wire logic        rx_runt_i,
  input  wire logic        rx_crc_err_i,
  input  wire logic        rx_release_i,
  output logic      [2:0]  rx_frame_count_o,
  // transmit queue side
  input  wire logic [12:0] tx_free_bytes_i,
  input  wire logic [12:0] next_tx_frame_size_req_i,
  input  wire logic        tx_frame_sent_i,
  output logic             tx_enqueue_o,
  output logic             tx_mem_avail_irq_o
);

  // ****************************************************************
  // state
  // ****************************************************************
  localparam int DEPTH = 4;

  typedef struct packed {
    logic [1:0]      wr_ptr;
    logic [1:0]      rd_ptr;
    logic [2:0]      count;
    logic            enq_cmd;
    logic            mon_cmd;
    logic            mon_fired;
    qfstc_tx_state_t tx_state;
    logic [12:0]     tx_free;
    logic [15:0]     rdata;
    logic            enq_pulse;
    logic            irq_pulse;
  } qfstc_state_t;

  qfstc_state_t st_ff;
  qfstc_state_t nxt_st;

  logic [15:0] stat_mem_ff [DEPTH];
  logic [11:0] bcnt_mem_ff [DEPTH];

  logic [15:0] new_status;
  logic        accept;
  logic        pop;
  logic        wr_cmd;
  logic        rd_hit;
  logic        rd_req;
  logic        q_empty;
  logic        q_full;
  logic        bad_drop;
  logic        enq_wr;
  logic        mon_wr;

  // pointers wrap at the queue depth, a power of two
  function automatic logic [1:0] inc_ptr(input logic [1:0] p);
    inc_ptr = p + 2'h1;
  endfunction

  function automatic logic [2:0] inc_cnt(input logic [2:0] c);
    inc_cnt = c + 3'h1;
  endfunction

  function automatic logic hit(input logic [10:0] a, input logic [10:0] o);
    hit = (a[10:1] == o[10:1]);
  endfunction

  // ****************************************************************
  // status encoder
  // ****************************************************************
  qfstc_rx_classify u_classify (
    .dest_addr_i (rx_dest_addr_i),
    .len_type_i  (rx_len_type_i),
    .icmp_err_i  (rx_icmp_err_i),
    .iphdr_err_i (rx_iphdr_err_i),
    .tcp_err_i   (rx_tcp_err_i),
    .udp_err_i   (rx_udp_err_i),
    .runt_i      (rx_runt_i),
    .crc_err_i   (rx_crc_err_i),
    .status_o    (new_status)
  );

  // ****************************************************************
  // shared decode
  // ****************************************************************
  assign q_empty  = (st_ff.count == 3'h0);
  assign q_full   = (st_ff.count == 3'(DEPTH));
  // bad frames are dropped unless the host asked to see them
  assign bad_drop = ~pass_bad_frame_i
                  & (rx_runt_i | rx_crc_err_i);
  // a full queue drops the frame silently; nothing is overwritten
  assign accept   = rx_frame_done_i & ~bad_drop & ~q_full;
  // release only meaningful while a frame is queued
  assign pop      = rx_release_i & ~q_empty;
  assign rd_req   = reg_sel_i & reg_rd_i;
  assign wr_cmd   = reg_sel_i & reg_wr_i & reg_be_i[0]
                  & hit(reg_addr_i, QFSTC_OFS_TXQ_CMD);
  // a write may carry both commands; each bit is judged alone
  assign enq_wr   = wr_cmd & reg_wdata_i[QFSTC_B_ENQ];
  assign mon_wr   = wr_cmd & reg_wdata_i[QFSTC_B_MON];

  // ****************************************************************
  // frame store
  // ****************************************************************
  // no reset on the store: words are only read while counted
  always_ff @(posedge sys_clk_i)
  begin
    if (accept)
    begin
      stat_mem_ff[st_ff.wr_ptr] <= new_status;
      bcnt_mem_ff[st_ff.wr_ptr] <= rx_frame_bytes_i;
    end
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb
  begin
    nxt_st           = st_ff;
    nxt_st.enq_pulse = 1'b0;
    nxt_st.irq_pulse = 1'b0;
    rd_hit           = 1'b0;

    if (accept)
    begin
      nxt_st.wr_ptr = inc_ptr(st_ff.wr_ptr);
    end
    if (pop)
    begin
      nxt_st.rd_ptr = inc_ptr(st_ff.rd_ptr);
    end
    case ({accept, pop})
      2'b10:   nxt_st.count = inc_cnt(st_ff.count);
      2'b01:   nxt_st.count = st_ff.count - 3'h1;
      default: nxt_st.count = st_ff.count;
    endcase

    // copied every cycle; the monitor compares against this copy
    nxt_st.tx_free = tx_free_bytes_i;

    // transmit command handling
    case (st_ff.tx_state)
      QFSTC_TX_IDLE:
      begin
        // one enqueue per command; later writes are ignored until the self-clear
        if (enq_wr & ~st_ff.enq_cmd)
        begin
          nxt_st.enq_cmd   = 1'b1;
          nxt_st.enq_pulse = 1'b1;
          nxt_st.tx_state  = QFSTC_TX_BUSY;
        end
      end
      QFSTC_TX_BUSY:
      begin
        if (tx_frame_sent_i)
        begin
          nxt_st.enq_cmd  = 1'b0;
          nxt_st.mon_cmd  = 1'b0;
          nxt_st.tx_state = QFSTC_TX_IDLE;
        end
      end
      default: nxt_st.tx_state = QFSTC_TX_IDLE;
    endcase

    // second write while armed is ignored until self-clear
    if (mon_wr & ~st_ff.mon_cmd)
    begin
      nxt_st.mon_cmd   = 1'b1;
      nxt_st.mon_fired = 1'b0;
    end
    else if (st_ff.mon_cmd & ~st_ff.mon_fired
             & (st_ff.tx_free >= next_tx_frame_size_req_i))
    begin
      nxt_st.irq_pulse = 1'b1;
      nxt_st.mon_fired = 1'b1;
    end
    // monitor without a frame in flight clears once it has fired
    if (st_ff.mon_fired & (st_ff.tx_state == QFSTC_TX_IDLE) & ~mon_wr)
    begin
      nxt_st.mon_cmd = 1'b0;
    end

    // read data registered on each read strobe
    if (rd_req)
    begin
      rd_hit       = 1'b1;
      nxt_st.rdata = QFSTC_ZERO16;
      if (hit(reg_addr_i, QFSTC_OFS_RX_STATUS))
      begin
        if (~q_empty)
        begin
          nxt_st.rdata = stat_mem_ff[st_ff.rd_ptr];
          nxt_st.rdata[QFSTC_B_VALID] = 1'b1;
        end
      end
      else if (hit(reg_addr_i, QFSTC_OFS_RX_BCNT))
      begin
        if (~q_empty)
        begin
          // low byte first in 8-bit mode; word held, so any order is safe
          nxt_st.rdata[QFSTC_BCNT_W-1:0] =
            bcnt_mem_ff[st_ff.rd_ptr];
        end
      end
      else if (hit(reg_addr_i, QFSTC_OFS_TXQ_CMD))
      begin
        nxt_st.rdata[QFSTC_B_ENQ] = st_ff.enq_cmd;
        nxt_st.rdata[QFSTC_B_MON] = st_ff.mon_cmd;
      end
      else if (hit(reg_addr_i, QFSTC_OFS_TX_FREE))
      begin
        nxt_st.rdata[QFSTC_FREE_W-1:0] = st_ff.tx_free;
      end
      // unmapped words read as zero
      else
      begin
        nxt_st.rdata = QFSTC_ZERO16;
      end
    end
    if (!rd_hit)
    begin
      nxt_st.rdata = st_ff.rdata;
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge sys_clk_i)
  begin
    if (!rstn_i)
    begin
      st_ff.wr_ptr    <= 2'h0;
      st_ff.rd_ptr    <= 2'h0;
      st_ff.count     <= 3'h0;
      st_ff.enq_cmd   <= 1'b0;
      st_ff.mon_cmd   <= 1'b0;
      st_ff.mon_fired <= 1'b0;
      st_ff.tx_state  <= QFSTC_TX_IDLE;
      st_ff.tx_free   <= QFSTC_FREE_RST;
      st_ff.rdata     <= QFSTC_ZERO16;
      st_ff.enq_pulse <= 1'b0;
      st_ff.irq_pulse <= 1'b0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign reg_rdata_o        = st_ff.rdata;
  assign rx_frame_count_o   = st_ff.count;
  assign tx_enqueue_o       = st_ff.enq_pulse;
  assign tx_mem_avail_irq_o = st_ff.irq_pulse;

endmodule

// [verilog/qfstc_pkg.sv]
// Purpose: shared constants for the queue frame status and tx command slice
// Assumes: 16-bit register words at even byte offsets of the host bus
// Notes:   offsets are byte addresses of the low byte of each word
package qfstc_pkg;

  // ****************************************************************
  // register offsets
  // ****************************************************************
  localparam logic [10:0] QFSTC_OFS_TX_FREE   = 11'h178;
  localparam logic [10:0] QFSTC_OFS_RX_STATUS = 11'h17c;
  localparam logic [10:0] QFSTC_OFS_RX_BCNT   = 11'h17e;
  localparam logic [10:0] QFSTC_OFS_TXQ_CMD   = 11'h180;

  // ****************************************************************
  // status word field positions
  // ****************************************************************
  localparam int QFSTC_B_VALID  = 15;
  localparam int QFSTC_B_ICMP   = 13;
  localparam int QFSTC_B_IPHDR  = 12;
  localparam int QFSTC_B_TCP    = 11;
  localparam int QFSTC_B_UDP    = 10;
  localparam int QFSTC_B_BCAST  = 7;
  localparam int QFSTC_B_MCAST  = 6;
  localparam int QFSTC_B_UCAST  = 5;
  localparam int QFSTC_B_ETYPE  = 3;
  localparam int QFSTC_B_RUNT   = 1;
  localparam int QFSTC_B_CRC    = 0;

  // ****************************************************************
  // command bits, widths, reset values
  // ****************************************************************
  localparam int QFSTC_B_ENQ = 0;
  localparam int QFSTC_B_MON = 1;
  localparam int QFSTC_BCNT_W = 12;
  localparam int QFSTC_FREE_W = 13;
  localparam logic [12:0] QFSTC_FREE_RST = 13'h1800;
  localparam logic [15:0] QFSTC_ETYPE_MIN = 16'h05dc;
  localparam logic [15:0] QFSTC_ZERO16    = 16'h0000;

  typedef enum logic [1:0]
  {
    QFSTC_TX_IDLE = 2'b00,
    QFSTC_TX_BUSY = 2'b01
  } qfstc_tx_state_t;

endpackage

// [verilog/qfstc_rx_classify.sv]
// Purpose: builds the frame status word from raw receive frame attributes
// Assumes: attributes are stable while rx_frame_done_i is high
// Notes:   purely combinational
`timescale 1ns/1ps
module qfstc_rx_classify
  import qfstc_pkg::*;
(
  // raw frame attributes
  input  wire logic [47:0] dest_addr_i,
  input  wire logic [15:0] len_type_i,
  input  wire logic        icmp_err_i,
  input  wire logic        iphdr_err_i,
  input  wire logic        tcp_err_i,
  input  wire logic        udp_err_i,
  input  wire logic        runt_i,
  input  wire logic        crc_err_i,
  // encoded status word, valid bit left clear
  output logic      [15:0] status_o
);

  logic bcast;
  logic mcast;

  always_comb
  begin
    bcast    = &dest_addr_i;
    // group bit is the lsb of the first octet sent
    mcast    = dest_addr_i[40];
    status_o = QFSTC_ZERO16;
    status_o[QFSTC_B_ICMP]  = icmp_err_i;
    status_o[QFSTC_B_IPHDR] = iphdr_err_i;
    status_o[QFSTC_B_TCP]   = tcp_err_i;
    status_o[QFSTC_B_UDP]   = udp_err_i;
    status_o[QFSTC_B_BCAST] = bcast;
    status_o[QFSTC_B_MCAST] = mcast | bcast;
    status_o[QFSTC_B_UCAST] = ~mcast & ~bcast;
    // meaningless for runts, still reported
    status_o[QFSTC_B_ETYPE] = len_type_i > QFSTC_ETYPE_MIN;
    status_o[QFSTC_B_RUNT]  = runt_i;
    status_o[QFSTC_B_CRC]   = crc_err_i;
  end

endmodule

// [bench/qfstc_sva.sv]
// Purpose: port-level checks on the queue frame status and tx command slice
// Assumes: sees only the top module's ports
// Notes:   bound into every qfstc_top instance
`timescale 1ns/1ps
module qfstc_chk
  import qfstc_pkg::*;
(
  // ****************************************************************
  // watched ports
  // ****************************************************************
  input wire logic        sys_clk_i,
  input wire logic        rstn_i,
  input wire logic        reg_sel_i,
  input wire logic        reg_wr_i,
  input wire logic        reg_rd_i,
  input wire logic [10:0] reg_addr_i,
  input wire logic [1:0]  reg_be_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic        rx_frame_done_i,
  input wire logic        rx_release_i,
  input wire logic [2:0]  rx_frame_count_o,
  input wire logic [12:0] tx_free_bytes_i,
  input wire logic [12:0] next_tx_frame_size_req_i,
  input wire logic        tx_enqueue_o,
  input wire logic        tx_mem_avail_irq_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  logic       rd_req;
  logic       wr_req;
  logic [9:0] wa;
  assign rd_req = reg_sel_i && reg_rd_i;
  assign wr_req = reg_sel_i && reg_wr_i;
  assign wa     = reg_addr_i[10:1];
  a_enq_cause: assert property
    (tx_enqueue_o |-> $past(wr_req && reg_be_i[0]
     && wa == QFSTC_OFS_TXQ_CMD[10:1] && reg_wdata_i[0]))
    else $error("enqueue pulse without command write");
  a_enq_once: assert property
    (tx_enqueue_o |=> !tx_enqueue_o)
    else $error("enqueue pulse longer than one cycle");
  a_irq_space: assert property
    (tx_mem_avail_irq_o |-> $past(tx_free_bytes_i, 2)
     >= $past(next_tx_frame_size_req_i))
    else $error("memory interrupt with too little space");
  a_irq_once: assert property
    (tx_mem_avail_irq_o |=> !tx_mem_avail_irq_o)
    else $error("memory interrupt longer than one cycle");
  a_count_max: assert property (rx_frame_count_o <= 3'h4)
    else $error("frame count beyond queue depth");
  a_count_up: assert property
    (rx_frame_count_o > $past(rx_frame_count_o) |-> $past(rx_frame_done_i))
    else $error("frame count rose without a frame");
  a_count_down: assert property
    (rx_frame_count_o < $past(rx_frame_count_o) |-> $past(rx_release_i))
    else $error("frame count fell without release");
  a_valid_empty: assert property
    (rd_req && wa == QFSTC_OFS_RX_STATUS[10:1] && rx_frame_count_o == 3'h0
     |=> !reg_rdata_o[15])
    else $error("valid bit set with empty queue");
  a_valid_held: assert property
    (rd_req && wa == QFSTC_OFS_RX_STATUS[10:1] && rx_frame_count_o != 3'h0
     |=> reg_rdata_o[15])
    else $error("valid bit clear with queued frame");
  a_bcnt_top: assert property
    (rd_req && wa == QFSTC_OFS_RX_BCNT[10:1] |=> reg_rdata_o[15:12] == 4'h0)
    else $error("byte count reserved bits not zero");
endmodule
bind qfstc_top qfstc_chk CHK (.*);

// [bench/qfstc_host_model.sv]
// Purpose: host cpu model driving the register port
// Assumes: 16-bit bus mode, whole words per access
// Notes:   released address and data lines show the inverse value
`timescale 1ns/1ps
module qfstc_host_model
(
  input  wire logic        sys_clk_i,
  input  wire logic [15:0] reg_rdata_i,
  output logic             reg_sel_o,
  output logic             reg_wr_o,
  output logic             reg_rd_o,
  output logic      [10:0] reg_addr_o,
  output logic      [1:0]  reg_be_o,
  output logic      [15:0] reg_wdata_o
);
  // ****************************************************************
  // one access: drive on falling edge, hold over the taking edge
  // ****************************************************************
  // word accesses only, so low-before-high byte order never arises
  initial
  begin
    {reg_sel_o, reg_wr_o, reg_rd_o, reg_be_o} = 5'h00;
    {reg_addr_o, reg_wdata_o} = 27'h0;
  end
  task automatic xfer(input logic w, input logic [10:0] a,
                      input logic [15:0] d, output logic [15:0] q);
    @(negedge sys_clk_i);
    {reg_sel_o, reg_wr_o, reg_rd_o, reg_be_o} = {1'b1, w, !w, 2'h3};
    {reg_addr_o, reg_wdata_o} = {a, d};
    @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    q = reg_rdata_i;
    {reg_sel_o, reg_wr_o, reg_rd_o, reg_be_o} = 5'h00;
    {reg_addr_o, reg_wdata_o} = ~{a, d};
  endtask
endmodule

// [bench/tb_queue_frame_status_and_tx_command.sv]
// Purpose: directed tests of rx frame status and tx queue commands
// Assumes: host model drives the register port on falling edges
// Notes:   expected words are built here from the field layout
`timescale 1ns/1ps
module tb_queue_frame_status_and_tx_command import qfstc_pkg::*;;
  // ****************************************************************
  // stimulus, scenarios and verdict
  // ****************************************************************
  logic        sys_clk_i, rstn_i, pass_bad_frame_i, rx_frame_done_i;
  logic        rx_release_i, tx_frame_sent_i, reg_sel_i, reg_wr_i;
  logic        reg_rd_i, rx_icmp_err_i, rx_iphdr_err_i, rx_tcp_err_i;
  logic        rx_udp_err_i, rx_runt_i, rx_crc_err_i;
  logic        tx_enqueue_o, tx_mem_avail_irq_o;
  logic [1:0]  reg_be_i;
  logic [2:0]  rx_frame_count_o;
  logic [10:0] reg_addr_i;
  logic [11:0] rx_frame_bytes_i;
  logic [12:0] tx_free_bytes_i, next_tx_frame_size_req_i;
  logic [15:0] reg_wdata_i, reg_rdata_o, rx_len_type_i, q, e;
  logic [47:0] rx_dest_addr_i;
  int          errors, comparisons, n_irq;
  localparam logic [47:0] DA [4] = '{48'hffffffffffff, 48'h01005e000001,
                                     48'h001122334455, 48'h001122334455};
  localparam logic [15:0] LT [4] = '{16'h0800, 16'h05dc, 16'h05dd, 16'h0040};
  localparam logic [5:0]  ER [4] = '{6'h00, 6'h20, 6'h1c, 6'h03};
  localparam logic [11:0] NB [4] = '{12'h040, 12'hfff, 12'h5ee, 12'h03c};
  qfstc_top DUT (.*);
  qfstc_host_model HOST (.sys_clk_i, .reg_rdata_i(reg_rdata_o),
    .reg_sel_o(reg_sel_i), .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i),
    .reg_addr_o(reg_addr_i), .reg_be_o(reg_be_i), .reg_wdata_o(reg_wdata_i));
  initial
  begin
    sys_clk_i = 1'b0;
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i) if (tx_mem_avail_irq_o === 1'b1) n_irq++;
  task automatic check(input string nm, input logic [15:0] seen, exp);
    comparisons++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic rd(input logic [10:0] a);
    HOST.xfer(1'b0, a, 16'h0000, q);
  endtask
  task automatic wr(input logic [10:0] a, input logic [15:0] d);
    HOST.xfer(1'b1, a, d, q);
  endtask
  function automatic logic [15:0] stat(input int i);
    return {2'b10, ER[i][5:2], 2'b00, &DA[i], DA[i][40], !DA[i][40], 1'b0,
            LT[i] > 16'h05dc, 1'b0, ER[i][1:0]};
  endfunction
  task automatic push(input int i);
    @(negedge sys_clk_i);
    {rx_dest_addr_i, rx_len_type_i, rx_frame_bytes_i} = {DA[i], LT[i], NB[i]};
    {rx_frame_done_i, rx_icmp_err_i, rx_iphdr_err_i, rx_tcp_err_i,
     rx_udp_err_i, rx_runt_i, rx_crc_err_i} = {1'b1, ER[i]};
    @(negedge sys_clk_i);
    {rx_frame_done_i, rx_dest_addr_i} = {1'b0, ~DA[i]};
  endtask
  task automatic pulse_release();
    @(negedge sys_clk_i) rx_release_i = 1'b1;
    @(negedge sys_clk_i) rx_release_i = 1'b0;
  endtask
  task automatic pulse_sent();
    @(negedge sys_clk_i) tx_frame_sent_i = 1'b1;
    @(negedge sys_clk_i) tx_frame_sent_i = 1'b0;
  endtask
  task automatic t_free();
    rd(QFSTC_OFS_TX_FREE);
    check("free at reset", q, 16'h1800);
    rd(QFSTC_OFS_TX_FREE);
    check("free", q, 16'h0a00);
  endtask
  task automatic t_rx();
    pass_bad_frame_i = 1'b1;
    for (int i = 0; i < 5; i++) push(i % 4);
    check("count full", 16'(rx_frame_count_o), 16'h0004);
    for (int i = 0; i < 4; i++)
    begin
      e = stat(i);
      rd(QFSTC_OFS_RX_STATUS);
      check("status", q, e);
      check("status lo", q & 16'hff, e & 16'hff);
      rd(QFSTC_OFS_RX_BCNT);
      check("byte count", q, {4'h0, NB[i]});
      pulse_release();
      check("count", 16'(rx_frame_count_o), 16'(3 - i));
    end
    rd(QFSTC_OFS_RX_STATUS);
    check("valid empty", 16'(q[15]), 16'h0000);
  endtask
  task automatic t_drop();
    pass_bad_frame_i = 1'b0;
    push(3);
    check("bad dropped", 16'(rx_frame_count_o), 16'h0000);
  endtask
  task automatic t_tx();
    wr(QFSTC_OFS_TXQ_CMD, 16'h0001);
    check("enqueue", 16'(tx_enqueue_o), 16'h0001);
    rd(QFSTC_OFS_TXQ_CMD);
    check("enq busy", q & 16'h0001, 16'h0001);
    wr(QFSTC_OFS_TXQ_CMD, 16'h0001);
    check("enq refused", 16'(tx_enqueue_o), 16'h0000);
    pulse_sent();
    rd(QFSTC_OFS_TXQ_CMD);
    check("enq cleared", q & 16'h0001, 16'h0000);
    wr(QFSTC_OFS_TXQ_CMD, 16'h0001);
    check("enqueue again", 16'(tx_enqueue_o), 16'h0001);
    pulse_sent();
  endtask
  task automatic t_mon();
    tx_free_bytes_i = 13'h0080;
    wr(QFSTC_OFS_TXQ_CMD, 16'h0002);
    repeat (4) @(negedge sys_clk_i);
    check("no irq", 16'(n_irq), 16'h0000);
    rd(QFSTC_OFS_TXQ_CMD);
    check("mon set", q & 16'h0002, 16'h0002);
    tx_free_bytes_i = 13'h0100;
    repeat (8) @(negedge sys_clk_i);
    check("irq once", 16'(n_irq), 16'h0001);
    rd(QFSTC_OFS_TXQ_CMD);
    check("mon cleared", q & 16'h0002, 16'h0000);
  endtask
  task automatic final_report();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    {rstn_i, pass_bad_frame_i, rx_frame_done_i, rx_release_i} = 4'h0;
    {rx_icmp_err_i, rx_iphdr_err_i, rx_tcp_err_i} = 3'h0;
    {rx_udp_err_i, rx_runt_i, rx_crc_err_i, tx_frame_sent_i} = 4'h0;
    {rx_dest_addr_i, rx_len_type_i, rx_frame_bytes_i} = 76'h0;
    {tx_free_bytes_i, next_tx_frame_size_req_i} = {13'h0a00, 13'h0100};
    // release lands with the first read so the reset free value is seen
    @(negedge sys_clk_i);
    fork
      @(negedge sys_clk_i) rstn_i = 1'b1;
      t_free();
    join
    t_rx();
    t_drop();
    t_tx();
    t_mon();
    final_report();
  end
  initial
  begin
    #100000;
    errors++;
    final_report();
  end
endmodule
